/* File: hw/rsc_top.sv */
`timescale 1ns/1ps
// How it works
// - Six sources: pin, power-on, brown-out, software, watchdog, oscillator failure.
// - Power-on resets core, peripherals and test-access controller.
// - Pin reset hits core and peripherals; test-access only gets pin config reset.
// - Brown-out, watchdog, oscillator failure reset core and peripherals, not test access.
// - Software system request resets core and peripherals, not test access.
// - Software peripheral reset touches only selected peripherals.
// - Flag of the responsible source is set after each reset.
// - Cause flags are sticky except through power-on or pin resets.
// - Power-on or pin cause clears all other flags.
// - Power-on reset held until power-on detect goes inactive.
// - After release core fetches stack pointer, program counter, instruction, then runs.
// - Power-on detect only counts during initial power-up.
// - Interrupt pin is plain GPIO after reset until reconfigured.
// - Brown-out acts like watchdog reset while low supply; needs enable bit.
module rsc_top #(
  parameter int NUM_PERIPH = 8
) (
  input  wire logic                  core_clk,
  input  wire logic                  rst_n,
  input  wire logic                  ext_reset_pin_n,
  input  wire logic                  por_detect,
  input  wire logic                  brownout_detect,
  input  wire logic                  wdt_reset,
  input  wire logic                  main_oscillator_fail,
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  output logic                       irq,
  output logic                       core_rst_n,
  output logic                       periph_rst_n,
  output logic      [NUM_PERIPH-1:0] periph_sel_rst_n,
  output logic                       jtag_rst_n,
  output logic                       jtag_pin_cfg_rst_n,
  output logic                       nmi_pin_is_nmi,
  output logic      [2:0]            boot_stage
);
  rsc_src_if src ();

  logic [5:0]            raw;
  logic [5:0]            sync_src;
  logic [5:0]            reset_cause_flags;
  logic [5:0]            next_cause;
  logic [5:0]            irq_status;
  logic [5:0]            irq_en;
  logic [7:0]            ctrl;
  logic [NUM_PERIPH-1:0] periph_ctrl;
  logic                  por_seen;
  logic                  sys_req_pulse;
  logic                  core_hold;
  logic                  jtag_hold;
  logic                  core_rst_q;
  logic                  core_rst_d;
  logic                  rel_edge;
  logic [5:0]            latched;
  rsc_pkg::rsc_boot_t    boot;
  logic                  wr_ctrl;
  logic                  wr_periph;
  logic                  wr_en;
  logic                  wr_clr;
  logic [5:0]            clr_mask;
  logic                  bor_gated;
  logic                  wr_open;

  // Raw source levels, brown-out not yet gated by enable
  assign raw[rsc_pkg::CAUSE_EXT]  = ~ext_reset_pin_n;
  assign raw[rsc_pkg::CAUSE_POR]  = por_detect;
  assign raw[rsc_pkg::CAUSE_BOR]  = brownout_detect;
  assign raw[rsc_pkg::CAUSE_SW]   = 1'b0;
  assign raw[rsc_pkg::CAUSE_WDT]  = wdt_reset;
  assign raw[rsc_pkg::CAUSE_MAIN_OSCILLATOR] = main_oscillator_fail;

  // Pin-side levels cross into the core clock
  rsc_sync #(.W(6)) u_sync (
    .core_clk (core_clk),
    .rst_n    (rst_n),
    .async_in (raw),
    .sync_out (sync_src)
  );

  // Power-on detect only honoured until its first fall
  always_ff @(posedge core_clk) begin
    if (!rst_n) por_seen <= 1'b0;
    else if (src.por == 1'b0 && sync_src[rsc_pkg::CAUSE_POR]) por_seen <= 1'b0;
    else if (sync_src[rsc_pkg::CAUSE_POR]) por_seen <= 1'b1;
    else if (por_seen) por_seen <= 1'b1;
  end

  logic por_done;
  always_ff @(posedge core_clk) begin
    if (!rst_n) por_done <= 1'b0;
    else if (por_seen && !sync_src[rsc_pkg::CAUSE_POR]) por_done <= 1'b1;
  end

  assign src.por    = sync_src[rsc_pkg::CAUSE_POR] & ~por_done;
  // Brown-out enable applied only after the pin level is synchronised
  assign bor_gated  = sync_src[rsc_pkg::CAUSE_BOR] & ctrl[rsc_pkg::CTRL_BOR_EN];
  assign src.active = {sync_src[5:4], sys_req_pulse, bor_gated, src.por, sync_src[0]};

  // Domain hold terms
  assign core_hold = |src.active;
  assign jtag_hold = src.por;

  // Core and peripheral reset, released after all sources drop
  rsc_release u_core_rel (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hold      (core_hold),
    .dom_rst_n (core_rst_d)
  );

  rsc_release u_jtag_rel (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .hold      (jtag_hold),
    .dom_rst_n (jtag_rst_n)
  );

  assign core_rst_n         = core_rst_d;
  assign periph_rst_n       = core_rst_d;
  // Per-peripheral reset: domain reset or software select, core untouched
  assign periph_sel_rst_n   = {NUM_PERIPH{core_rst_d}} & ~periph_ctrl;

  // Test-port pin configuration reset, registered like the other resets
  always_ff @(posedge core_clk) begin
    if (!rst_n) jtag_pin_cfg_rst_n <= 1'b0;
    else jtag_pin_cfg_rst_n <= jtag_rst_n & ~src.active[rsc_pkg::CAUSE_EXT];
  end

  // Strobe-qualified match of one register offset
  function automatic logic reg_hit(input logic       strobe,
                                   input logic [3:0] addr,
                                   input logic [3:0] ofs);
    reg_hit = strobe && (addr == ofs);
  endfunction
  // Register write decode; writes are ignored while the core is in reset
  assign wr_open   = reg_wr & core_rst_d;
  assign wr_ctrl   = reg_hit(reg_wr, reg_addr, rsc_pkg::OFS_CTRL);
  assign wr_periph = reg_hit(reg_wr, reg_addr, rsc_pkg::OFS_PERIPH);
  assign wr_en     = reg_hit(wr_open, reg_addr, rsc_pkg::OFS_IRQ_EN);
  assign wr_clr    = reg_hit(wr_open, reg_addr, rsc_pkg::OFS_IRQ_CLR);
  assign clr_mask  = wr_clr ? reg_wdata[5:0] : 6'h00;

  // Control and selection registers; core reset clears all but brown-out enable
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ctrl          <= rsc_pkg::CTRL_RST;
      periph_ctrl   <= '0;
      sys_req_pulse <= 1'b0;
    end else if (!core_rst_d) begin
      // Keeping the enable lets a low supply hold reset until it recovers
      ctrl          <= {rsc_pkg::CTRL_RST[7:1], ctrl[rsc_pkg::CTRL_BOR_EN]};
      periph_ctrl   <= '0;
      sys_req_pulse <= 1'b0;
    end else begin
      sys_req_pulse <= wr_ctrl & reg_wdata[rsc_pkg::CTRL_SYS_REQ];
      if (wr_ctrl) ctrl <= {reg_wdata[7:2], 1'b0, reg_wdata[0]};
      if (wr_periph) periph_ctrl <= reg_wdata[NUM_PERIPH-1:0];
    end
  end

  assign nmi_pin_is_nmi = ctrl[rsc_pkg::CTRL_NMI_SEL];

  // Latch which sources took part in the current reset
  always_ff @(posedge core_clk) begin
    if (!rst_n) latched <= 6'h00;
    else if (rel_edge) latched <= 6'h00;
    else latched <= latched | src.active;
  end

  assign rel_edge = core_rst_d & ~core_rst_q;

  // Cause update at release: power-on or pin wipes the others
  always_comb begin
    next_cause = reset_cause_flags;
    if (rel_edge) begin
      if (latched[rsc_pkg::CAUSE_POR])
        next_cause = 6'h01 << rsc_pkg::CAUSE_POR;
      else if (latched[rsc_pkg::CAUSE_EXT])
        next_cause = 6'h01 << rsc_pkg::CAUSE_EXT;
      else
        next_cause = reset_cause_flags | latched;
    end
  end

  // Sticky cause flags survive all but the full reset and power-on or pin causes
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      reset_cause_flags <= 6'h00;
      core_rst_q        <= 1'b0;
    end else begin
      reset_cause_flags <= next_cause;
      core_rst_q        <= core_rst_d;
    end
  end

  // Interrupt status: set on each cause update, set beats clear
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      irq_status <= 6'h00;
      irq_en     <= 6'h00;
    end else begin
      irq_status <= (irq_status & ~clr_mask) | (rel_edge ? latched : 6'h00);
      if (wr_en) irq_en <= reg_wdata[5:0];
    end
  end

  assign irq = |(irq_status & irq_en);

  // Boot fetch sequence after internal reset release
  always_ff @(posedge core_clk) begin
    if (!rst_n || !core_rst_d) boot <= rsc_pkg::RSC_HOLD;
    else begin
      case (boot)
        rsc_pkg::RSC_HOLD:       boot <= rsc_pkg::RSC_FETCH_SP;
        rsc_pkg::RSC_FETCH_SP:   boot <= rsc_pkg::RSC_FETCH_PC;
        rsc_pkg::RSC_FETCH_PC:   boot <= rsc_pkg::RSC_FETCH_INSN;
        default:                 boot <= rsc_pkg::RSC_RUN;
      endcase
    end
  end

  assign boot_stage = boot;

  // Read data, one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!rst_n || !reg_rd) reg_rdata <= 32'h0000_0000;
    else if (reg_addr == rsc_pkg::OFS_CAUSE) reg_rdata <= {26'h0, reset_cause_flags};
    else if (reg_addr == rsc_pkg::OFS_CTRL) reg_rdata <= {24'h0, ctrl};
    else if (reg_addr == rsc_pkg::OFS_PERIPH) reg_rdata <= 32'(periph_ctrl);
    else if (reg_addr == rsc_pkg::OFS_IRQ_ST) reg_rdata <= {26'h0, irq_status};
    else if (reg_addr == rsc_pkg::OFS_IRQ_EN) reg_rdata <= {26'h0, irq_en};
    else if (reg_addr == rsc_pkg::OFS_STAGE) reg_rdata <= {29'h0, boot};
    else reg_rdata <= 32'h0000_0000;
  end
endmodule // rsc_top

/* File: hw/rsc_pkg.sv */
package rsc_pkg;
  // Number of reset sources
  localparam int NUM_SRC = 6;
  // Cause flag positions
  localparam int CAUSE_EXT  = 0;
  localparam int CAUSE_POR  = 1;
  localparam int CAUSE_BOR  = 2;
  localparam int CAUSE_SW   = 3;
  localparam int CAUSE_WDT  = 4;
  localparam int CAUSE_MAIN_OSCILLATOR = 5;
  // Register offsets
  localparam logic [3:0] OFS_CAUSE   = 4'h0;
  localparam logic [3:0] OFS_CTRL    = 4'h1;
  localparam logic [3:0] OFS_PERIPH  = 4'h2;
  localparam logic [3:0] OFS_IRQ_ST  = 4'h3;
  localparam logic [3:0] OFS_IRQ_EN  = 4'h4;
  localparam logic [3:0] OFS_IRQ_CLR = 4'h5;
  localparam logic [3:0] OFS_STAGE   = 4'h6;
  // Control register bit positions
  localparam int CTRL_BOR_EN  = 0;
  localparam int CTRL_SYS_REQ = 1;
  localparam int CTRL_NMI_SEL = 2;
  // Reset values
  localparam logic [7:0] CTRL_RST = 8'h00;
  // Release count reached after all sources drop; the internal reset rises one cycle after it is reached
  localparam int RELEASE_CYCLES = 4;
  // Boot fetch stages after release
  typedef enum logic [2:0] {
    RSC_HOLD, RSC_FETCH_SP, RSC_FETCH_PC, RSC_FETCH_INSN, RSC_RUN
  } rsc_boot_t;
endpackage

/* File: hw/rsc_src_if.sv */
`timescale 1ns/1ps
// Synchronised reset source levels
interface rsc_src_if;
  logic [5:0] active;
  logic       por;
  modport drv (output active, output por);
  modport rcv (input active, input por);
endinterface

/* File: hw/rsc_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for asynchronous reset sources
module rsc_sync #(
  parameter int W = 6
) (
  input  wire logic         core_clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] stage1;

  // Both stages reset inactive
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end
endmodule // rsc_sync

/* File: hw/rsc_release.sv */
`timescale 1ns/1ps
// Holds a reset low while any source is active, then counts off release
module rsc_release #(
  parameter int CYCLES = rsc_pkg::RELEASE_CYCLES
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic hold,
  output logic      dom_rst_n
);
  logic [7:0] cnt;
  logic       done;

  assign done = (cnt == 8'(CYCLES));

  // Restart the count whenever a source is active
  always_ff @(posedge core_clk) begin
    if (!rst_n || hold) begin
      cnt       <= 8'h00;
      dom_rst_n <= 1'b0;
    end else begin
      if (!done) cnt <= cnt + 8'h01;
      dom_rst_n <= done;
    end
  end
endmodule // rsc_release

/* File: sim/rsc_partner.sv */
`timescale 1ns/1ps
// Reset pin driver and supply monitor beside the reset block
module rsc_partner #(
  parameter int TMIN       = 8,
  parameter int POR_CYCLES = 6
) (
  input  wire logic       core_clk,
  input  wire logic [1:0] go,
  output logic            ext_reset_pin_n,
  output logic            por_detect,
  output logic            brownout_detect
);
  int c0 = 0;
  int c1 = 0;
  int cp = 0;
  // Power-on detect high only from power-up until it first drops
  always @(posedge core_clk) if (cp < POR_CYCLES) cp <= cp + 1;
  assign por_detect = (cp < POR_CYCLES);
  // Pin held low at least TMIN after a request; low supply likewise
  always @(posedge core_clk) begin
    c0 <= go[0] ? TMIN : (c0 > 0 ? c0 - 1 : 0);
    c1 <= go[1] ? TMIN : (c1 > 0 ? c1 - 1 : 0);
  end
  assign ext_reset_pin_n = (c0 == 0);
  assign brownout_detect = (c1 != 0);
endmodule // rsc_partner

/* File: sim/rsc_top_monitor.sv */
`timescale 1ns/1ps
// Timing relations of the reset outputs
module rsc_top_monitor (
  input wire logic        core_clk,
  input wire logic        rst_n,
  input wire logic        ext_reset_pin_n,
  input wire logic        por_detect,
  input wire logic        wdt_reset,
  input wire logic        main_oscillator_fail,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        core_rst_n,
  input wire logic        periph_rst_n,
  input wire logic        jtag_rst_n,
  input wire logic        jtag_pin_cfg_rst_n,
  input wire logic        nmi_pin_is_nmi,
  input wire logic [2:0]  boot_stage
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire quiet = ext_reset_pin_n && !wdt_reset && !main_oscillator_fail;
  sequence s_core_src;
    !ext_reset_pin_n || wdt_reset || main_oscillator_fail;
  endsequence
  sequence s_boot;
    boot_stage == 3'h1 ##1 boot_stage == 3'h2 ##1 boot_stage == 3'h3 ##1 boot_stage == 3'h4;
  endsequence
  a_src_holds_core: assert property (s_core_src [*5] |-> !core_rst_n && !periph_rst_n)
    else $error("core or peripherals not held in reset");
  a_pin_cfg_rst: assert property (!ext_reset_pin_n [*5] |-> !jtag_pin_cfg_rst_n)
    else $error("pin config reset missing");
  a_jtag_kept: assert property (jtag_rst_n && !por_detect |=> jtag_rst_n)
    else $error("test access reset without power-on");
  a_release_gap: assert property ($rose(core_rst_n) |-> $past(quiet, 4))
    else $error("core released too early");
  a_hold_stage: assert property (!core_rst_n && !$past(core_rst_n) |-> boot_stage == 3'h0)
    else $error("boot stage moved during reset");
  a_boot_order: assert property ($rose(core_rst_n) |-> ##[0:1] s_boot)
    else $error("boot fetch order wrong");
  a_nmi_gpio: assert property (!core_rst_n |=> !nmi_pin_is_nmi)
    else $error("interrupt pin not plain io after reset");
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
    else $error("read data outside read slot");
endmodule // rsc_top_monitor
bind rsc_top rsc_top_monitor i_mon (.core_clk(core_clk), .rst_n(rst_n),
  .ext_reset_pin_n(ext_reset_pin_n), .por_detect(por_detect), .wdt_reset(wdt_reset),
  .main_oscillator_fail(main_oscillator_fail), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .core_rst_n(core_rst_n),
  .periph_rst_n(periph_rst_n), .jtag_rst_n(jtag_rst_n),
  .jtag_pin_cfg_rst_n(jtag_pin_cfg_rst_n), .nmi_pin_is_nmi(nmi_pin_is_nmi),
  .boot_stage(boot_stage));

/* File: sim/reset_source_control_test.sv */
`timescale 1ns/1ps
module reset_source_control_test;
  logic        core_clk  = 1'b0;
  logic        rst_n     = 1'b0;
  logic [3:0]  ev        = 4'h0;
  logic [3:0]  reg_addr  = 4'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr    = 1'b0;
  logic        reg_rd    = 1'b0;
  logic        rd_d      = 1'b0;
  logic [31:0] reg_rdata;
  logic        irq, core_rst_n, periph_rst_n, jtag_rst_n, pin_cfg_n, nmi;
  logic [7:0]  psel_n;
  logic [2:0]  stage;
  wire         ext_n, por, bor;
  logic [31:0] exq[$];
  logic [5:0]  cause;
  logic [7:0]  pv;
  int          fail_count = 0;
  int          compares = 0;
  rsc_top #(.NUM_PERIPH(8)) i_rsc_top (.core_clk(core_clk), .rst_n(rst_n),
    .ext_reset_pin_n(ext_n), .por_detect(por), .brownout_detect(bor),
    .wdt_reset(ev[0]), .main_oscillator_fail(ev[1]), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .core_rst_n(core_rst_n), .periph_rst_n(periph_rst_n), .periph_sel_rst_n(psel_n),
    .jtag_rst_n(jtag_rst_n), .jtag_pin_cfg_rst_n(pin_cfg_n), .nmi_pin_is_nmi(nmi),
    .boot_stage(stage));
  rsc_partner i_rsc_partner (.core_clk(core_clk), .go(ev[3:2]), .ext_reset_pin_n(ext_n),
    .por_detect(por), .brownout_detect(bor));
  initial forever #5 core_clk = ~core_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic give_verdict;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Read data compared against the oldest note in the slot after the strobe
  always @(posedge core_clk) rd_d <= reg_rd;
  always @(negedge core_clk) if (rd_d) chk(reg_rdata, exq.pop_front());
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    reg_addr <= a; reg_rd <= 1'b1; exq.push_back(e);
    @(posedge core_clk);
    reg_rd <= 1'b0;
  endtask
  // Bounded wait for the core reset to reach a level
  task automatic waitv(input logic v);
    int n;
    n = 0;
    while (core_rst_n !== v) begin
      @(posedge core_clk);
      n++;
      if (n > 60) begin fail_count++; give_verdict(); end
    end
  endtask
  task automatic nap;
    repeat (2) @(posedge core_clk);
    #1;
  endtask
  // Raise one event for five cycles and wait through the reset it causes
  task automatic fire(input int i);
    @(posedge core_clk);
    ev[i] <= 1'b1;
    repeat (5) @(posedge core_clk);
    ev[i] <= 1'b0;
    waitv(1'b0); waitv(1'b1);
    chk(bor, 32'h0);
    nap;
  endtask
  initial begin
    void'($urandom(32616));
    repeat (2) @(posedge core_clk);
    rst_n <= 1'b1;
    waitv(1'b1); nap;
    cause = 6'h1 << rsc_pkg::CAUSE_POR;
    rd(rsc_pkg::OFS_CAUSE, {26'h0, cause});
    $display("power-on test done");
    for (int i = 0; i < 2; i++) begin
      fire(i);
      cause |= 6'h1 << (i == 0 ? rsc_pkg::CAUSE_WDT : rsc_pkg::CAUSE_MAIN_OSCILLATOR);
      rd(rsc_pkg::OFS_CAUSE, {26'h0, cause});
      chk(jtag_rst_n, 32'h1);
    end
    wr(rsc_pkg::OFS_CTRL, 32'h1 << rsc_pkg::CTRL_SYS_REQ);
    waitv(1'b0); waitv(1'b1); nap;
    cause |= 6'h1 << rsc_pkg::CAUSE_SW;
    rd(rsc_pkg::OFS_CAUSE, {26'h0, cause});
    wr(rsc_pkg::OFS_CTRL, 32'h1 << rsc_pkg::CTRL_BOR_EN);
    fire(3);
    cause |= 6'h1 << rsc_pkg::CAUSE_BOR;
    rd(rsc_pkg::OFS_CAUSE, {26'h0, cause});
    $display("core source tests done");
    wr(rsc_pkg::OFS_CTRL, 32'h1 << rsc_pkg::CTRL_NMI_SEL);
    nap;
    chk(nmi, 32'h1);
    fire(2);
    rd(rsc_pkg::OFS_CAUSE, 32'h1 << rsc_pkg::CAUSE_EXT);
    chk(nmi, 32'h0);
    chk(jtag_rst_n, 32'h1);
    $display("pin reset test done");
    pv = 8'($urandom);
    wr(rsc_pkg::OFS_PERIPH, {24'h0, pv});
    nap;
    chk(psel_n, {24'h0, ~pv});
    chk(core_rst_n, 32'h1);
    wr(rsc_pkg::OFS_PERIPH, 32'h0);
    nap;
    chk(psel_n, 32'hff);
    $display("peripheral reset test done");
    wr(rsc_pkg::OFS_IRQ_CLR, 32'h3f);
    wr(rsc_pkg::OFS_IRQ_EN, 32'h0);
    fire(0);
    chk(irq, 32'h0);
    wr(rsc_pkg::OFS_IRQ_EN, 32'h3f);
    nap;
    chk(irq, 32'h1);
    rd(rsc_pkg::OFS_IRQ_ST, 32'h1 << rsc_pkg::CAUSE_WDT);
    wr(rsc_pkg::OFS_IRQ_CLR, 32'h3f);
    nap;
    chk(irq, 32'h0);
    rd(4'hf, 32'h0);
    $display("interrupt test done");
    repeat (3) @(posedge core_clk);
    give_verdict();
  end
endmodule // reset_source_control_test
